// ---- core/sam_pkg.sv ----
// constants, encodings and register map of the shift/acc-load/mac execution unit
package sam_pkg;

	localparam int WORD_W      = 16;
	localparam int ACC_W       = 40;
	localparam int WIDE_W      = 48;
	localparam int INSTR_W     = 24;
	localparam int NUM_W       = 16;
	localparam int EVT_W       = 7;
	localparam int MIN_ADDR_W  = 6;

	// opcode prefixes
	localparam logic [7:0] OP_ACC_LOAD    = 8'hca;
	localparam logic [9:0] OP_FRAME_ALLOC = 10'h3e8;
	localparam logic [8:0] OP_LSR_FILE    = 9'h1aa;
	localparam logic [8:0] OP_LSR_REG     = 9'h1bc;
	localparam logic [4:0] OP_MAC         = 5'h18;
	localparam logic [2:0] LSR_LIT_FORM   = 3'h4;
	localparam logic [2:0] LSR_REG_FORM   = 3'h0;

	// field positions (lsb)
	localparam int F_ACC_SEL   = 15;
	localparam int F_ALD_BASE  = 11;
	localparam int F_ALD_SHIFT = 7;
	localparam int F_ALD_MODE  = 4;
	localparam int F_SRC       = 0;
	localparam int F_LIT_HI    = 13;
	localparam int F_LSRF_BYTE = 14;
	localparam int F_LSRF_DEST = 13;
	localparam int F_FILE      = 0;
	localparam int F_LSR_BASE  = 11;
	localparam int F_LSR_WND   = 7;
	localparam int F_LSR_FORM  = 4;
	localparam int F_LSR_CNT   = 0;
	localparam int F_MAC_MUL   = 16;
	localparam int F_MAC_ZERO  = 14;
	localparam int F_MAC_XD    = 12;
	localparam int F_MAC_YD    = 10;
	localparam int F_MAC_XPF   = 6;
	localparam int F_MAC_YPF   = 2;
	localparam int F_MAC_WBK   = 0;

	// source addressing modes of the accumulator load
	localparam logic [2:0] AM_DIRECT   = 3'h0;
	localparam logic [2:0] AM_POST_DEC = 3'h2;
	localparam logic [2:0] AM_POST_INC = 3'h3;
	localparam logic [2:0] AM_PRE_DEC  = 3'h4;
	localparam logic [2:0] AM_PRE_INC  = 3'h5;
	localparam logic [1:0] AM_INDEX_HI = 2'h3;

	// mac prefetch and write-back codes
	localparam logic [3:0] PF_NONE  = 4'h4;
	localparam logic [3:0] PF_INDEX = 4'hc;
	localparam logic [1:0] WBK_REG  = 2'h0;
	localparam logic [1:0] WBK_MEM  = 2'h1;
	localparam logic [2:0] MUL_BAD0 = 3'h3;
	localparam logic [2:0] MUL_BAD1 = 3'h7;

	// working register numbers
	localparam logic [3:0] W_DEFAULT = 4'h0;
	localparam logic [3:0] W_X0      = 4'h8;
	localparam logic [3:0] W_X1      = 4'h9;
	localparam logic [3:0] W_Y0      = 4'ha;
	localparam logic [3:0] W_Y1      = 4'hb;
	localparam logic [3:0] W_INDEX   = 4'hc;
	localparam logic [3:0] W_WBK     = 4'hd;
	localparam logic [3:0] W_FRAME   = 4'he;
	localparam logic [3:0] W_STACK   = 4'hf;
	localparam logic [1:0] W_PREF_HI = 2'h1;

	localparam logic [15:0] WORD_STEP = 16'h0002;
	localparam logic [4:0]  MAX_SHIFT = 5'h0f;

	// saturation limits
	localparam logic [39:0] NORM_POS  = 40'h007fffffff;
	localparam logic [39:0] NORM_NEG  = 40'hff80000000;
	localparam logic [39:0] SUPER_POS = 40'h7fffffffff;
	localparam logic [39:0] SUPER_NEG = 40'h8000000000;

	// register map (byte addresses)
	localparam logic [7:0] REG_CTRL      = 8'h00;
	localparam logic [7:0] REG_STATUS    = 8'h04;
	localparam logic [7:0] REG_MASK      = 8'h08;
	localparam logic [7:0] REG_ALU_FLAGS = 8'h0c;
	localparam logic [7:0] REG_ACC_A_LO  = 8'h10;
	localparam logic [7:0] REG_ACC_A_HI  = 8'h14;
	localparam logic [7:0] REG_ACC_B_LO  = 8'h18;
	localparam logic [7:0] REG_ACC_B_HI  = 8'h1c;
	localparam logic [7:0] REG_WORK_SEL  = 8'h20;
	localparam logic [7:0] REG_WORK_DATA = 8'h24;

	// control bits
	localparam int CTRL_SAT_A = 0;
	localparam int CTRL_SAT_B = 1;
	localparam int CTRL_SUPER = 2;
	localparam logic [2:0] CTRL_RESET = 3'h0;

	// event bits
	localparam int EV_OV_A    = 0;
	localparam int EV_OV_B    = 1;
	localparam int EV_OV_ANY  = 2;
	localparam int EV_SAT_A   = 3;
	localparam int EV_SAT_B   = 4;
	localparam int EV_SAT_ANY = 5;
	localparam int EV_ILLEGAL = 6;

	// alu flag bits
	localparam int FL_CARRY = 0;
	localparam int FL_ZERO  = 1;
	localparam int FL_NEG   = 2;

	typedef enum logic [0:0] {
		ST_IDLE = 1'b0,
		ST_EXEC = 1'b1
	} sam_state_type;

	function automatic logic [15:0] sam_post_mod(input logic [2:0] code);
		unique case (code)
			3'h1:    sam_post_mod = 16'h0002;
			3'h2:    sam_post_mod = 16'h0004;
			3'h3:    sam_post_mod = 16'h0006;
			3'h5:    sam_post_mod = 16'hfffa;
			3'h6:    sam_post_mod = 16'hfffc;
			3'h7:    sam_post_mod = 16'hfffe;
			default: sam_post_mod = 16'h0000;
		endcase
	endfunction

	function automatic logic [7:0] sam_mul_pair(input logic [2:0] code);
		unique case (code)
			3'h0:    sam_mul_pair = 8'h45;
			3'h1:    sam_mul_pair = 8'h46;
			3'h2:    sam_mul_pair = 8'h47;
			3'h4:    sam_mul_pair = 8'h56;
			3'h5:    sam_mul_pair = 8'h57;
			default: sam_mul_pair = 8'h67;
		endcase
	endfunction

endpackage

// ---- core/sam_exec.sv ----
// execution unit: accumulator load, frame allocation, shift right, multiply-accumulate
// Behaviour
// - acc load shifts source into selected accumulator
// - shift -8..7, negative left, positive right
// - source as 1.15, sign extended, low zeros
// - acc load decodes 11001010 plus fields
// - overflow or saturation sets per/combined flags
// - push frame, sp+2, fp=sp, sp+=literal
// - frame literal 0..16382, lowest bit zero
// - file shift: lsb to carry, zero in
// - dest 0 writes default reg, 1 file
// - byte bit selects byte or word shift
// - literal-count shift right, zero fill, N/Z
// - register-count uses five low bits
// - count above fifteen writes zero
// - register shifts are word, direct only
// - mac adds fractional product of pair
// - mac prefetch with post-modify or index
// - mac writes rounded other accumulator back
`timescale 1ns/1ps
`default_nettype none

module sam_exec #(
	parameter int APB_ADDR_W = 8
) (
	input  wire logic                           clk,
	input  wire logic                           rst,
	input  wire logic                           psel,
	input  wire logic                           penable,
	input  wire logic                           pwrite,
	input  wire logic [APB_ADDR_W-1:0]          paddr,
	input  wire logic [31:0]                    pwdata,
	output var  logic [31:0]                    prdata,
	output var  logic                           pready,
	output var  logic                           pslverr,
	input  wire logic                           instr_valid,
	input  wire logic [sam_pkg::INSTR_W-1:0]    instr_word,
	output var  logic                           instr_ready,
	output var  logic [sam_pkg::WORD_W-1:0]     mem_rd_x_addr,
	output var  logic [sam_pkg::WORD_W-1:0]     mem_rd_y_addr,
	input  wire logic [sam_pkg::WORD_W-1:0]     mem_rd_x_data,
	input  wire logic [sam_pkg::WORD_W-1:0]     mem_rd_y_data,
	output var  logic                           mem_wr_en,
	output var  logic [sam_pkg::WORD_W-1:0]     mem_wr_addr,
	output var  logic [sam_pkg::WORD_W-1:0]     mem_wr_data,
	output var  logic [1:0]                     mem_wr_be,
	output var  logic                           irq
);
	import sam_pkg::*;

	generate
		if (APB_ADDR_W < MIN_ADDR_W) begin : g_bad_addr
			$error("apb address width too small for register map");
		end
	endgenerate

	sam_state_type      state;
	logic [15:0]        work [0:NUM_W-1];
	logic [15:0]        next_w [0:NUM_W-1];
	logic [39:0]        acc_a;
	logic [39:0]        acc_b;
	logic [23:0]        ir;
	logic [2:0]         ctrl;
	logic [EVT_W-1:0]   status;
	logic [EVT_W-1:0]   mask;
	logic [2:0]         alu_flags;
	logic [3:0]         wsel;

	// instruction in flight: live word while idle, latched word while executing
	wire        accept = (state == ST_IDLE) && instr_valid && instr_ready;
	wire        exec   = (state == ST_EXEC);
	wire [23:0] cur    = exec ? ir : instr_word;

	wire is_ald  = cur[23:16] == OP_ACC_LOAD;
	wire is_frm  = cur[23:14] == OP_FRAME_ALLOC;
	wire is_lsrf = cur[23:15] == OP_LSR_FILE;
	wire is_lsrl = (cur[23:15] == OP_LSR_REG) && (cur[F_LSR_FORM +: 3] == LSR_LIT_FORM);
	wire is_lsrr = (cur[23:15] == OP_LSR_REG) && (cur[F_LSR_FORM +: 3] == LSR_REG_FORM);
	wire [2:0] mul_code = cur[F_MAC_MUL +: 3];
	// only the six distinct pairs decode
	wire mul_ok  = (mul_code != MUL_BAD0) && (mul_code != MUL_BAD1);
	wire is_mac  = (cur[23:19] == OP_MAC) && !cur[F_MAC_ZERO] && mul_ok;
	wire legal   = is_ald || is_frm || is_lsrf || is_lsrl || is_lsrr || is_mac;
	wire sel_b   = cur[F_ACC_SEL];

	// accumulator load addressing
	wire [3:0]  src_i     = cur[F_SRC +: 4];
	wire [15:0] src_v     = work[src_i];
	wire [15:0] base_v    = work[cur[F_ALD_BASE +: 4]];
	wire [2:0]  ald_mode  = cur[F_ALD_MODE +: 3];
	wire        ald_index = ald_mode[2:1] == AM_INDEX_HI;
	wire [15:0] src_inc   = src_v + WORD_STEP;
	wire [15:0] src_dec   = src_v - WORD_STEP;
	wire [15:0] ald_ea    = ald_index ? src_v + base_v :
	                        (ald_mode == AM_PRE_DEC) ? src_dec :
	                        (ald_mode == AM_PRE_INC) ? src_inc : src_v;
	wire        ald_upd   = (ald_mode == AM_POST_DEC) || (ald_mode == AM_POST_INC) ||
	                        (ald_mode == AM_PRE_DEC) || (ald_mode == AM_PRE_INC);
	wire [15:0] ald_new   = ((ald_mode == AM_POST_INC) || (ald_mode == AM_PRE_INC)) ?
	                        src_inc : src_dec;

	// 1.15 source placed with sign extension and zero backfill
	wire [15:0]        ald_src = (ald_mode == AM_DIRECT) ? src_v : mem_rd_x_data;
	wire [47:0]        ald_ext = {{16{ald_src[15]}}, ald_src, 16'h0000};
	wire signed [3:0]  ald_sh  = cur[F_ALD_SHIFT +: 4];
	wire [3:0]         ald_amt = 4'(4'h0 - ald_sh);
	// negative count shifts left, positive arithmetic right
	wire [47:0]        ald_val = ald_sh[3] ? (ald_ext << ald_amt) :
	                             48'($signed(ald_ext) >>> ald_sh);

	// mac prefetch pointers
	wire [3:0]  x_pf     = cur[F_MAC_XPF +: 4];
	wire [3:0]  y_pf     = cur[F_MAC_YPF +: 4];
	wire [3:0]  x_ptr_i  = x_pf[3] ? W_X1 : W_X0;
	wire [3:0]  y_ptr_i  = y_pf[3] ? W_Y1 : W_Y0;
	wire [15:0] x_ptr_v  = work[x_ptr_i];
	wire [15:0] y_ptr_v  = work[y_ptr_i];
	wire        x_fetch  = is_mac && (x_pf != PF_NONE);
	wire        y_fetch  = is_mac && (y_pf != PF_NONE);
	wire        x_upd    = x_fetch && (x_pf != PF_INDEX);
	wire        y_upd    = y_fetch && (y_pf != PF_INDEX);
	// indexed by register twelve or post-modified by +-2/4/6
	wire [15:0] x_ea     = (x_pf == PF_INDEX) ? x_ptr_v + work[W_INDEX] : x_ptr_v;
	wire [15:0] y_ea     = (y_pf == PF_INDEX) ? y_ptr_v + work[W_INDEX] : y_ptr_v;
	wire [15:0] x_new    = x_ptr_v + sam_post_mod(x_pf[2:0]);
	wire [15:0] y_new    = y_ptr_v + sam_post_mod(y_pf[2:0]);
	wire [3:0]  xd_i     = {W_PREF_HI, cur[F_MAC_XD +: 2]};
	wire [3:0]  yd_i     = {W_PREF_HI, cur[F_MAC_YD +: 2]};
	wire [1:0]  wbk      = cur[F_MAC_WBK +: 2];

	// fractional product added to chosen accumulator
	wire [7:0]         pair    = sam_mul_pair(mul_code);
	wire signed [15:0] mul_a   = work[pair[7:4]];
	wire signed [15:0] mul_b   = work[pair[3:0]];
	wire signed [31:0] prod    = mul_a * mul_b;
	wire [39:0]        acc_t   = sel_b ? acc_b : acc_a;
	wire [47:0]        mac_sum = {{8{acc_t[39]}}, acc_t} + {{15{prod[31]}}, prod, 1'b0};

	wire [47:0] new_v   = is_mac ? mac_sum : ald_val;
	wire        sat_en  = sel_b ? ctrl[CTRL_SAT_B] : ctrl[CTRL_SAT_A];
	wire        cat_ov  = new_v[47:39] != {9{new_v[47]}};
	wire        ov31    = new_v[47:31] != {17{new_v[47]}};
	wire        do_sat  = sat_en && (ctrl[CTRL_SUPER] ? cat_ov : ov31);
	wire [39:0] sat_lim = ctrl[CTRL_SUPER] ? (new_v[47] ? SUPER_NEG : SUPER_POS) :
	                      (new_v[47] ? NORM_NEG : NORM_POS);
	wire [39:0] acc_res = do_sat ? sat_lim : new_v[39:0];
	wire        acc_ov  = acc_res[39:31] != {9{acc_res[39]}};
	wire        acc_act = exec && (is_ald || is_mac);

	wire [39:0] acc_o = sel_b ? acc_a : acc_b;
	wire [15:0] rnd   = acc_o[31:16] + {15'h0000, acc_o[15]};

	// literal lowest bit forced to zero
	wire [15:0] frame_lit = {2'b00, cur[F_LIT_HI:1], 1'b0};
	wire [15:0] sp_inc    = work[W_STACK] + WORD_STEP;
	wire [15:0] sp_new    = sp_inc + frame_lit;

	// byte lane select and byte or word shift
	wire [12:0] f_addr   = cur[F_FILE +: 13];
	wire        f_byte   = cur[F_LSRF_BYTE];
	wire        f_dest   = cur[F_LSRF_DEST];
	wire [7:0]  f_b      = f_addr[0] ? mem_rd_x_data[15:8] : mem_rd_x_data[7:0];
	// zero into msb, lsb out to carry
	wire [15:0] f_res    = f_byte ? {9'h000, f_b[7:1]} : {1'b0, mem_rd_x_data[15:1]};
	wire        f_carry  = f_byte ? f_b[0] : mem_rd_x_data[0];
	wire        f_zero   = f_byte ? (f_res[7:0] == 8'h00) : (f_res == 16'h0000);
	wire [1:0]  f_be     = f_byte ? (f_addr[0] ? 2'b10 : 2'b01) : 2'b11;

	wire [15:0] lsr_base = work[cur[F_LSR_BASE +: 4]];
	wire [3:0]  wnd_i    = cur[F_LSR_WND +: 4];
	wire [15:0] cnt_reg  = work[cur[F_LSR_CNT +: 4]];
	// five low bits of the count register
	wire [4:0]  lsr_cnt  = is_lsrl ? {1'b0, cur[F_LSR_CNT +: 4]} : cnt_reg[4:0];
	wire [15:0] lsr_res  = (lsr_cnt > MAX_SHIFT) ? 16'h0000 : (lsr_base >> lsr_cnt);

	// memory write selection
	wire        wr_frm  = exec && is_frm;
	wire        wr_file = exec && is_lsrf && f_dest;
	wire        wr_wbk  = exec && is_mac && (wbk == WBK_MEM);
	wire        wr_any  = wr_frm || wr_file || wr_wbk;
	wire [15:0] wr_addr = wr_frm ? work[W_STACK] : wr_file ? {3'b000, f_addr} : work[W_WBK];
	wire [15:0] wr_data = wr_frm ? work[W_FRAME] : wr_file ? (f_byte ? {2{f_res[7:0]}} : f_res) : rnd;
	wire [1:0]  wr_be   = wr_file ? f_be : 2'b11;

	// read-address selection at issue
	wire [15:0] rd_x = is_ald ? ald_ea : is_lsrf ? {3'b000, f_addr} : x_ea;

	// apb decode
	wire apb_acc = psel && penable && !pready;
	wire apb_wr  = apb_acc && pwrite;
	wire hit_ctrl   = paddr == APB_ADDR_W'(REG_CTRL);
	wire hit_status = paddr == APB_ADDR_W'(REG_STATUS);
	wire hit_mask   = paddr == APB_ADDR_W'(REG_MASK);
	wire hit_flags  = paddr == APB_ADDR_W'(REG_ALU_FLAGS);
	wire hit_a_lo   = paddr == APB_ADDR_W'(REG_ACC_A_LO);
	wire hit_a_hi   = paddr == APB_ADDR_W'(REG_ACC_A_HI);
	wire hit_b_lo   = paddr == APB_ADDR_W'(REG_ACC_B_LO);
	wire hit_b_hi   = paddr == APB_ADDR_W'(REG_ACC_B_HI);
	wire hit_wsel   = paddr == APB_ADDR_W'(REG_WORK_SEL);
	wire hit_wdata  = paddr == APB_ADDR_W'(REG_WORK_DATA);
	wire mapped = hit_ctrl || hit_status || hit_mask || hit_flags || hit_a_lo || hit_a_hi ||
	              hit_b_lo || hit_b_hi || hit_wsel || hit_wdata;
	wire [31:0] rd_mux = hit_ctrl   ? {29'h0, ctrl} :
	                     hit_status ? {25'h0, status} :
	                     hit_mask   ? {25'h0, mask} :
	                     hit_flags  ? {29'h0, alu_flags} :
	                     hit_a_lo   ? acc_a[31:0] :
	                     hit_a_hi   ? {24'h0, acc_a[39:32]} :
	                     hit_b_lo   ? acc_b[31:0] :
	                     hit_b_hi   ? {24'h0, acc_b[39:32]} :
	                     hit_wsel   ? {28'h0, wsel} :
	                     hit_wdata  ? {16'h0, work[wsel]} : 32'h0;

	// events: set wins over a same-cycle clear
	wire [EVT_W-1:0] evt;
	assign evt[EV_OV_A]    = acc_act && !sel_b && acc_ov;
	assign evt[EV_OV_B]    = acc_act && sel_b && acc_ov;
	assign evt[EV_OV_ANY]  = acc_act && acc_ov;
	assign evt[EV_SAT_A]   = acc_act && !sel_b && do_sat;
	assign evt[EV_SAT_B]   = acc_act && sel_b && do_sat;
	assign evt[EV_SAT_ANY] = acc_act && do_sat;
	assign evt[EV_ILLEGAL] = exec && !legal;
	wire [EVT_W-1:0] st_clr      = (apb_wr && hit_status) ? pwdata[EVT_W-1:0] : '0;
	wire [EVT_W-1:0] next_status = (status & ~st_clr) | evt;

	// register file next values; execution overrides a bus write
	always_comb begin
		for (int i = 0; i < NUM_W; i++) begin
			next_w[i] = work[i];
		end
		if (apb_wr && hit_wdata) begin
			next_w[wsel] = pwdata[15:0];
		end
		if (exec) begin
			if (is_ald && ald_upd) begin
				next_w[src_i] = ald_new;
			end
			// frame pointer gets sp+2, sp advances by 2 plus literal
			if (is_frm) begin
				next_w[W_FRAME] = sp_inc;
				next_w[W_STACK] = sp_new;
			end
			// destination zero goes to default register
			if (is_lsrf && !f_dest) begin
				next_w[W_DEFAULT] = f_byte ? {work[W_DEFAULT][15:8], f_res[7:0]} : f_res;
			end
			if (is_lsrl || is_lsrr) begin
				next_w[wnd_i] = lsr_res;
			end
			if (is_mac) begin
				if (x_upd) begin
					next_w[x_ptr_i] = x_new;
				end
				if (y_upd) begin
					next_w[y_ptr_i] = y_new;
				end
				if (x_fetch) begin
					next_w[xd_i] = mem_rd_x_data;
				end
				if (y_fetch) begin
					next_w[yd_i] = mem_rd_y_data;
				end
				// write-back to register or through it with +2
				if (wbk == WBK_REG) begin
					next_w[W_WBK] = rnd;
				end else if (wbk == WBK_MEM) begin
					next_w[W_WBK] = work[W_WBK] + WORD_STEP;
				end
			end
		end
	end

	// issue edge then one execute edge per instruction
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state       <= ST_IDLE;
			instr_ready <= 1'b1;
			ir          <= '0;
		end else if (accept) begin
			state       <= ST_EXEC;
			instr_ready <= 1'b0;
			ir          <= instr_word;
		end else if (exec) begin
			state       <= ST_IDLE;
			instr_ready <= 1'b1;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			mem_rd_x_addr <= '0;
			mem_rd_y_addr <= '0;
		end else if (accept) begin
			mem_rd_x_addr <= rd_x;
			mem_rd_y_addr <= y_ea;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			mem_wr_en   <= 1'b0;
			mem_wr_addr <= '0;
			mem_wr_data <= '0;
			mem_wr_be   <= '0;
		end else begin
			mem_wr_en   <= wr_any;
			mem_wr_addr <= wr_addr;
			mem_wr_data <= wr_data;
			mem_wr_be   <= wr_be;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < NUM_W; i++) begin
				work[i] <= '0;
			end
		end else begin
			for (int i = 0; i < NUM_W; i++) begin
				work[i] <= next_w[i];
			end
		end
	end

	// result into the accumulator chosen by the select bit
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			acc_a <= '0;
			acc_b <= '0;
		end else if (acc_act && !sel_b) begin
			acc_a <= acc_res;
		end else if (acc_act && sel_b) begin
			acc_b <= acc_res;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			alu_flags <= '0;
		end else if (exec && is_lsrf) begin
			alu_flags <= {f_byte ? f_res[7] : f_res[15], f_zero, f_carry};
		end else if (exec && (is_lsrl || is_lsrr)) begin
			alu_flags <= {lsr_res[15], lsr_res == 16'h0000, alu_flags[FL_CARRY]};
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			status <= '0;
			irq    <= 1'b0;
		end else begin
			status <= next_status;
			irq    <= |(next_status & mask);
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ctrl <= CTRL_RESET;
			mask <= '0;
			wsel <= '0;
		end else if (apb_wr) begin
			ctrl <= hit_ctrl ? pwdata[2:0] : ctrl;
			mask <= hit_mask ? pwdata[EVT_W-1:0] : mask;
			wsel <= hit_wsel ? pwdata[3:0] : wsel;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= '0;
		end else begin
			pready  <= apb_acc;
			pslverr <= apb_acc && !mapped;
			prdata  <= (apb_acc && !pwrite) ? rd_mux : 32'h0;
		end
	end

endmodule

`default_nettype wire

// ---- test/sam_exec_properties.sv ----
// port checker for the execution unit
`timescale 1ns/1ps
`default_nettype none
module sam_exec_properties (
	input wire logic                        clk,
	input wire logic                        rst,
	input wire logic                        psel,
	input wire logic                        penable,
	input wire logic                        pready,
	input wire logic                        pslverr,
	input wire logic [31:0]                 prdata,
	input wire logic                        instr_valid,
	input wire logic [sam_pkg::INSTR_W-1:0] instr_word,
	input wire logic                        instr_ready,
	input wire logic                        mem_wr_en,
	input wire logic [1:0]                  mem_wr_be
);
	import sam_pkg::*;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	wire logic take = instr_valid && instr_ready;
	wire logic is_frm = take && instr_word[23:14] == OP_FRAME_ALLOC;
	wire logic is_ald = take && instr_word[23:16] == OP_ACC_LOAD;
	wire logic is_lsrf = take && instr_word[23:15] == OP_LSR_FILE;
	wire logic is_lsrr = take && instr_word[23:15] == OP_LSR_REG;
	wire logic is_mac = take && instr_word[23:19] == OP_MAC;
	chk_ready_gap: assert property (take |=> !instr_ready ##1 instr_ready)
		else $error("instr_ready gap wrong");
	chk_wr_cause: assert property (mem_wr_en |-> $past(take, 2) && !$past(mem_wr_en))
		else $error("memory write without instruction");
	chk_frame_push: assert property (is_frm |-> ##2 mem_wr_en && mem_wr_be == 2'h3)
		else $error("frame push missing");
	chk_lsr_byte: assert property (is_lsrf && instr_word[F_LSRF_BYTE] && instr_word[F_LSRF_DEST]
		|-> ##2 mem_wr_en && mem_wr_be != 2'h3 && mem_wr_be != 2'h0)
		else $error("byte shift lanes wrong");
	chk_default_work_reg_dest: assert property (is_lsrf && !instr_word[F_LSRF_DEST] |-> ##2 !mem_wr_en)
		else $error("shift to work reg wrote memory");
	chk_load_nowr: assert property (is_ald |-> ##2 !mem_wr_en)
		else $error("acc load wrote memory");
	chk_lsr_nowr: assert property (is_lsrr |-> ##2 !mem_wr_en)
		else $error("register shift wrote memory");
	chk_mac_writeback: assert property (is_mac && instr_word[1:0] == WBK_MEM
		|-> ##2 mem_wr_en && mem_wr_be == 2'h3)
		else $error("mac write-back missing");
	chk_pready_pulse: assert property (psel && penable && !pready |=> pready ##1 !pready)
		else $error("pready not a one-cycle answer");
	chk_read_idle: assert property (!pready |-> prdata == 32'h0 && !pslverr)
		else $error("read data outside answer");
	cover property (is_frm);
	cover property (is_mac);
	cover property (pready && pslverr);
endmodule
bind sam_exec sam_exec_properties sam_exec_properties_inst (.clk, .rst, .psel, .penable,
	.pready, .pslverr, .prdata, .instr_valid, .instr_word, .instr_ready, .mem_wr_en, .mem_wr_be);
`default_nettype wire

// ---- test/sam_mem_model.sv ----
// data memory model with two read ports and a byte-lane write port
`timescale 1ns/1ps
`default_nettype none
module sam_mem_model (
	input  wire logic        clk,
	input  wire logic [15:0] rd_x_addr,
	input  wire logic [15:0] rd_y_addr,
	output logic      [15:0] rd_x_data,
	output logic      [15:0] rd_y_data,
	input  wire logic        wr_en,
	input  wire logic [15:0] wr_addr,
	input  wire logic [15:0] wr_data,
	input  wire logic [1:0]  wr_be
);
	logic [15:0] mem [0:32767];
	assign rd_x_data = mem[rd_x_addr[15:1]];
	assign rd_y_data = mem[rd_y_addr[15:1]];
	always @(posedge clk) begin
		if (wr_en && wr_be[0])
			mem[wr_addr[15:1]][7:0] <= wr_data[7:0];
		if (wr_en && wr_be[1])
			mem[wr_addr[15:1]][15:8] <= wr_data[15:8];
	end
endmodule
`default_nettype wire

// ---- test/sam_exec_test.sv ----
// testbench for the execution unit
`timescale 1ns/1ps
`default_nettype none
module sam_exec_test;
	import sam_pkg::*;
	logic clk, rst, psel, penable, pwrite, pready, pslverr, instr_valid, instr_ready;
	logic mem_wr_en, irq, rerr;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rdat;
	logic [23:0] instr_word;
	logic [15:0] xa, ya, xd, yd, wa, wd;
	logic [1:0]  wbe;
	logic [39:0] accv;
	int fail_count, n_tests, cycles, k;
	sam_exec sam_exec_inst (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .instr_valid, .instr_word, .instr_ready, .mem_rd_x_addr(xa),
		.mem_rd_y_addr(ya), .mem_rd_x_data(xd), .mem_rd_y_data(yd), .mem_wr_en,
		.mem_wr_addr(wa), .mem_wr_data(wd), .mem_wr_be(wbe), .irq);
	sam_mem_model sam_mem_model_inst (.clk, .rd_x_addr(xa), .rd_y_addr(ya), .rd_x_data(xd),
		.rd_y_data(yd), .wr_en(mem_wr_en), .wr_addr(wa), .wr_data(wd), .wr_be(wbe));
	task automatic summarize();
		$display("checks %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [39:0] seen, input logic [39:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1)
			@(posedge clk);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task automatic wset(input logic [3:0] n, input logic [15:0] v);
		apb(1'b1, REG_WORK_SEL, 32'(n));
		apb(1'b1, REG_WORK_DATA, 32'(v));
	endtask
	task automatic wchk(input logic [3:0] n, input logic [15:0] v);
		apb(1'b1, REG_WORK_SEL, 32'(n));
		apb(1'b0, REG_WORK_DATA, 32'h0);
		chk("work", rdat, 40'(v));
	endtask
	task automatic racc(input logic [7:0] a);
		apb(1'b0, a, 32'h0);
		accv[31:0] = rdat;
		apb(1'b0, a + 8'h04, 32'h0);
		accv[39:32] = rdat[7:0];
	endtask
	task automatic issue(input logic [23:0] w);
		instr_valid <= 1'b1;
		instr_word <= w;
		@(posedge clk);
		while (instr_ready !== 1'b1)
			@(posedge clk);
		instr_valid <= 1'b0;
		// memory write lands one edge after execute
		@(posedge clk);
		@(posedge clk);
		@(posedge clk);
	endtask
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			fail_count++;
			summarize();
		end
	end
	initial begin
		{psel, penable, pwrite, paddr, pwdata, instr_valid, instr_word} = '0;
		rst = 1'b1;
		sam_mem_model_inst.mem[16'h1000] = 16'h1221;
		sam_mem_model_inst.mem[16'h0300] = 16'h55ff;
		sam_mem_model_inst.mem[16'h0500] = 16'h2567;
		sam_mem_model_inst.mem[16'h0c00] = 16'h909c;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		wset(4'h4, 16'h2000);
		issue(24'hca86b4);
		racc(REG_ACC_B_LO);
		chk("acc_b", accv, 40'h0091080000);
		wchk(4'h4, 16'h2002);
		apb(1'b0, REG_STATUS, 32'h0);
		chk("status", rdat, 40'h6);
		chk("irq_masked", irq, 1'b0);
		apb(1'b1, REG_MASK, 32'h2);
		chk("irq_on", irq, 1'b1);
		apb(1'b1, REG_STATUS, 32'h6);
		chk("irq_off", irq, 1'b0);
		apb(1'b0, 8'h30, 32'h0);
		chk("slverr", rerr, 1'b1);
		wset(4'he, 16'h1234);
		wset(4'hf, 16'h2000);
		issue(24'hfa00a0);
		chk("push", sam_mem_model_inst.mem[16'h1000], 40'h1234);
		wchk(4'he, 16'h2002);
		wchk(4'hf, 16'h20a2);
		issue(24'hfa3ffe);
		wchk(4'he, 16'h20a4);
		wchk(4'hf, 16'h60a2);
		wset(4'h4, 16'hc800);
		issue(24'hde22ce);
		wchk(4'h5, 16'h0003);
		wset(4'h5, 16'hc800);
		for (k = 15; k <= 16; k++) begin
			wset(4'h4, 16'(k));
			issue(24'hde2984);
			wchk(4'h3, (k == 15) ? 16'h0001 : 16'h0000);
		end
		apb(1'b0, REG_ALU_FLAGS, 32'h0);
		chk("nz", rdat[2:1], 2'b01);
		issue(24'hd50600);
		wchk(4'h0, 16'h2aff);
		apb(1'b0, REG_ALU_FLAGS, 32'h0);
		chk("carry", rdat[0], 1'b1);
		issue(24'hd56600);
		chk("byte", sam_mem_model_inst.mem[16'h0300], 40'h557f);
		wset(4'h4, 16'ha022);
		wset(4'h5, 16'hb900);
		wset(4'h8, 16'h0a00);
		wset(4'ha, 16'h1800);
		issue(24'hc004c4);
		racc(REG_ACC_A_LO);
		chk("acc_a", accv, 40'h00352d2400);
		wchk(4'h4, 16'h2567);
		wchk(4'h5, 16'h909c);
		wchk(4'h8, 16'h0a06);
		wchk(4'ha, 16'h1802);
		wchk(4'hd, 16'h9108);
		issue(24'hc004c5);
		chk("awb_mem", sam_mem_model_inst.mem[16'h4884], 40'h9108);
		wchk(4'hd, 16'h910a);
		wset(4'h1, 16'h4000);
		apb(1'b1, REG_CTRL, 32'h1);
		apb(1'b1, REG_STATUS, 32'h7f);
		issue(24'hca0401);
		racc(REG_ACC_A_LO);
		chk("acc_a_sat", accv, 40'h007fffffff);
		apb(1'b0, REG_STATUS, 32'h0);
		chk("status_sat", rdat, 40'h28);
		summarize();
	end
endmodule
`default_nettype wire
